// >>> logic/iccr_pkg.sv
/*
 Package for the impedance channel configuration register: offsets, field layout,
 reset values and decoded encodings.
 Assumes nothing of its surroundings.
*/
package iccr_pkg;
	// Register addressing
	localparam int ADDR_W = 8;
	localparam logic [7:0] CFG_OFFSET = 8'h18;
	localparam int DATA_W = 24;
	// Field positions
	localparam int RATE_BIT = 23;
	localparam int AHPF_HI = 22;
	localparam int AHPF_LO = 20;
	localparam int BIAS_BIT = 19;
	localparam int LN_BIT = 18;
	localparam int GAIN_HI = 17;
	localparam int GAIN_LO = 16;
	localparam int DHPF_HI = 15;
	localparam int DHPF_LO = 14;
	localparam int DLPF_HI = 13;
	localparam int DLPF_LO = 12;
	// Reset values
	localparam logic RATE_RST = 1'b0;
	localparam logic [2:0] AHPF_RST = 3'h2;
	localparam logic BIAS_RST = 1'b0;
	localparam logic LN_RST = 1'b0;
	localparam logic [1:0] GAIN_RST = 2'h0;
	localparam logic [1:0] DHPF_RST = 2'h0;
	localparam logic [1:0] DLPF_RST = 2'h1;
	// Low-pass codes
	localparam logic [1:0] DLPF_BYPASS = 2'h0;
	localparam logic [1:0] DLPF_4HZ = 2'h1;
	localparam logic [1:0] DLPF_16HZ = 2'h3;
	// Analog high-pass bypass codes have both top bits set
	localparam logic [1:0] AHPF_BYP_TOP = 2'h3;
	// Digital high-pass bypass code
	localparam logic [1:0] DHPF_BYPASS = 2'h0;
	// Rate codes, one-hot over the eight master-clock and rate combinations
	localparam int RATE_CODES = 8;
	// Zero word
	localparam logic [23:0] ZERO_WORD = 24'h00_0000;
endpackage

// >>> logic/iccr_impedance_channel_config_reg.sv
/*
 Impedance channel configuration register with effective low-pass remap on read.
 Assumes a plain register port: one-cycle strobes, read data in the next cycle,
 and the master clock select coming in from the general config register.
*/
`timescale 1ns/10ps
module iccr_impedance_channel_config_reg (
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [23:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [23:0] o_rdata,
	// From general config register
	input wire logic [1:0] i_master_clock_select,
	// Decoded channel controls
	output logic [7:0] o_rate_onehot,
	output logic o_impedance_rate_select,
	output logic [2:0] o_analog_highpass_select,
	output logic o_analog_highpass_bypass,
	output logic o_external_bias_select,
	output logic o_amp_low_noise_select,
	output logic [1:0] o_impedance_gain_select,
	output logic [1:0] o_digital_highpass_select,
	output logic o_digital_highpass_bypass,
	output logic [1:0] o_digital_lowpass_select,
	output logic o_digital_lowpass_fir_off
);
	logic rate_reg, rate_next;
	logic [2:0] ahpf_reg, ahpf_next;
	logic bias_reg, bias_next;
	logic ln_reg, ln_next;
	logic [1:0] gain_reg, gain_next;
	logic [1:0] dhpf_reg, dhpf_next;
	logic [1:0] dlpf_reg, dlpf_next;
	logic [23:0] rdata_reg, rdata_next;
	logic [1:0] dlpf_eff;
	logic [23:0] view;
	logic hit;

	// Assertion clock and reset for the whole block
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	// Request qualifiers shared by the checks
	sequence s_write_hit;
		i_wr && hit && i_clk_en;
	endsequence
	sequence s_read_hit;
		i_rd && hit && i_clk_en;
	endsequence
	sequence s_in_reset;
		!i_resetn;
	endsequence
	sequence s_frozen;
		!i_clk_en;
	endsequence

	// Address decode
	assign hit = (i_addr == iccr_pkg::CFG_OFFSET);

	// Effective low-pass: 16 Hz only at the fast rate, else run as 4 Hz
	always_comb begin
		dlpf_eff = dlpf_reg;
		if (dlpf_reg == iccr_pkg::DLPF_16HZ && rate_reg) begin
			dlpf_eff = iccr_pkg::DLPF_4HZ;
		end
	end

	// The remap touches only the 16 Hz code at the slow rates
	property p_keep_slow;
		(rate_reg && dlpf_reg != iccr_pkg::DLPF_16HZ) |-> o_digital_lowpass_select == dlpf_reg;
	endproperty
	a_keep_slow: assert property (p_keep_slow) else $error("low-pass altered at slow rate");

	// Read view carries the effective low-pass code
	always_comb begin
		view = iccr_pkg::ZERO_WORD;
		view[iccr_pkg::RATE_BIT] = rate_reg;
		view[iccr_pkg::AHPF_HI:iccr_pkg::AHPF_LO] = ahpf_reg;
		view[iccr_pkg::BIAS_BIT] = bias_reg;
		view[iccr_pkg::LN_BIT] = ln_reg;
		view[iccr_pkg::GAIN_HI:iccr_pkg::GAIN_LO] = gain_reg;
		view[iccr_pkg::DHPF_HI:iccr_pkg::DHPF_LO] = dhpf_reg;
		view[iccr_pkg::DLPF_HI:iccr_pkg::DLPF_LO] = dlpf_eff;
	end

	// Bits below the low-pass field belong to other logic and read as zero
	property p_low_bits_zero;
		o_rdata[iccr_pkg::DLPF_LO - 1:0] == '0;
	endproperty
	a_low_bits_zero: assert property (p_low_bits_zero) else $error("low bits not zero");

	// Next state of the fields and read data
	always_comb begin
		rate_next = rate_reg;
		ahpf_next = ahpf_reg;
		bias_next = bias_reg;
		ln_next = ln_reg;
		gain_next = gain_reg;
		dhpf_next = dhpf_reg;
		dlpf_next = dlpf_reg;
		rdata_next = iccr_pkg::ZERO_WORD;
		if (i_wr && hit) begin
			rate_next = i_wdata[iccr_pkg::RATE_BIT];
			ahpf_next = i_wdata[iccr_pkg::AHPF_HI:iccr_pkg::AHPF_LO];
			bias_next = i_wdata[iccr_pkg::BIAS_BIT];
			ln_next = i_wdata[iccr_pkg::LN_BIT];
			gain_next = i_wdata[iccr_pkg::GAIN_HI:iccr_pkg::GAIN_LO];
			dhpf_next = i_wdata[iccr_pkg::DHPF_HI:iccr_pkg::DHPF_LO];
			dlpf_next = i_wdata[iccr_pkg::DLPF_HI:iccr_pkg::DLPF_LO];
		end
		if (i_rd && hit) begin
			rdata_next = view;
		end
	end

	// Writes load every field; without a write nothing moves
	property p_write_fields;
		s_write_hit |=> {o_analog_highpass_select, o_external_bias_select, o_amp_low_noise_select,
			o_impedance_gain_select, o_digital_highpass_select}
			== $past(i_wdata[iccr_pkg::AHPF_HI:iccr_pkg::DHPF_LO]);
	endproperty
	a_write_fields: assert property (p_write_fields) else $error("field write lost");

	property p_keep_written;
		s_write_hit |=> dlpf_reg == $past(i_wdata[iccr_pkg::DLPF_HI:iccr_pkg::DLPF_LO]);
	endproperty
	a_keep_written: assert property (p_keep_written) else $error("low-pass not stored");

	property p_idle_keeps;
		(!i_wr && i_clk_en) |=> $stable(view);
	endproperty
	a_idle_keeps: assert property (p_idle_keeps) else $error("fields moved without write");

	property p_read_idle;
		(!i_rd && i_clk_en) |=> o_rdata == iccr_pkg::ZERO_WORD;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not cleared");

	property p_read_miss;
		(i_rd && !hit && i_clk_en) |=> o_rdata == iccr_pkg::ZERO_WORD;
	endproperty
	a_read_miss: assert property (p_read_miss) else $error("unmapped read not zero");

	// Register stage with clock enable
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			rate_reg <= iccr_pkg::RATE_RST;
			ahpf_reg <= iccr_pkg::AHPF_RST;
			bias_reg <= iccr_pkg::BIAS_RST;
			ln_reg <= iccr_pkg::LN_RST;
			gain_reg <= iccr_pkg::GAIN_RST;
			dhpf_reg <= iccr_pkg::DHPF_RST;
			dlpf_reg <= iccr_pkg::DLPF_RST;
			rdata_reg <= iccr_pkg::ZERO_WORD;
		end else if (i_clk_en) begin
			rate_reg <= rate_next;
			ahpf_reg <= ahpf_next;
			bias_reg <= bias_next;
			ln_reg <= ln_next;
			gain_reg <= gain_next;
			dhpf_reg <= dhpf_next;
			dlpf_reg <= dlpf_next;
			rdata_reg <= rdata_next;
		end
	end

	// Reset loads the field defaults, whatever the clock enable does
	property p_reset_rate;
		disable iff (1'b0) s_in_reset |=> o_impedance_rate_select == iccr_pkg::RATE_RST;
	endproperty
	a_reset_rate: assert property (p_reset_rate) else $error("rate reset wrong");

	property p_reset_ahpf;
		disable iff (1'b0) s_in_reset |=> o_analog_highpass_select == iccr_pkg::AHPF_RST;
	endproperty
	a_reset_ahpf: assert property (p_reset_ahpf) else $error("analog hp reset wrong");

	property p_reset_bias;
		disable iff (1'b0) s_in_reset |=> o_external_bias_select == iccr_pkg::BIAS_RST;
	endproperty
	a_reset_bias: assert property (p_reset_bias) else $error("bias reset wrong");

	property p_reset_ln;
		disable iff (1'b0) s_in_reset |=> o_amp_low_noise_select == iccr_pkg::LN_RST;
	endproperty
	a_reset_ln: assert property (p_reset_ln) else $error("power mode reset wrong");

	property p_reset_gain;
		disable iff (1'b0) s_in_reset |=> o_impedance_gain_select == iccr_pkg::GAIN_RST;
	endproperty
	a_reset_gain: assert property (p_reset_gain) else $error("gain reset wrong");

	property p_reset_dhpf;
		disable iff (1'b0) s_in_reset |=> o_digital_highpass_select == iccr_pkg::DHPF_RST;
	endproperty
	a_reset_dhpf: assert property (p_reset_dhpf) else $error("digital hp reset wrong");

	property p_reset_dlpf;
		disable iff (1'b0) s_in_reset |=> o_digital_lowpass_select == iccr_pkg::DLPF_RST;
	endproperty
	a_reset_dlpf: assert property (p_reset_dlpf) else $error("low-pass reset wrong");

	// Clock enable low holds every field and the read data
	property p_freeze;
		s_frozen |=> $stable(view) && $stable(o_rdata);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	// Rate select: index is master clock select times two plus the rate bit
	genvar g;
	generate
		for (g = 0; g < iccr_pkg::RATE_CODES; g++) begin : g_rate
			assign o_rate_onehot[g] = ({i_master_clock_select, rate_reg} == 3'(g));
		end
	endgenerate

	// Each master clock selection owns one pair of rate lines
	property p_rate_mclk0;
		(i_master_clock_select == 2'h0)
			|-> (o_rate_onehot[0] == !rate_reg) && (o_rate_onehot[1] == rate_reg);
	endproperty
	a_rate_mclk0: assert property (p_rate_mclk0) else $error("rate pair 0 wrong");

	property p_rate_mclk1;
		(i_master_clock_select == 2'h1)
			|-> (o_rate_onehot[2] == !rate_reg) && (o_rate_onehot[3] == rate_reg);
	endproperty
	a_rate_mclk1: assert property (p_rate_mclk1) else $error("rate pair 1 wrong");

	property p_rate_mclk2;
		(i_master_clock_select == 2'h2)
			|-> (o_rate_onehot[4] == !rate_reg) && (o_rate_onehot[5] == rate_reg);
	endproperty
	a_rate_mclk2: assert property (p_rate_mclk2) else $error("rate pair 2 wrong");

	property p_rate_mclk3;
		(i_master_clock_select == 2'h3)
			|-> (o_rate_onehot[6] == !rate_reg) && (o_rate_onehot[7] == rate_reg);
	endproperty
	a_rate_mclk3: assert property (p_rate_mclk3) else $error("rate pair 3 wrong");

	// Field outputs to the analog and digital channel
	assign o_rdata = rdata_reg;
	assign o_impedance_rate_select = rate_reg;
	assign o_analog_highpass_select = ahpf_reg;
	assign o_analog_highpass_bypass =
		(view[iccr_pkg::AHPF_HI:iccr_pkg::AHPF_LO + 1] == iccr_pkg::AHPF_BYP_TOP);
	assign o_external_bias_select = bias_reg;
	assign o_amp_low_noise_select = ln_reg;
	assign o_impedance_gain_select = gain_reg;
	assign o_digital_highpass_select = dhpf_reg;
	assign o_digital_highpass_bypass = (dhpf_reg == iccr_pkg::DHPF_BYPASS);
	assign o_digital_lowpass_select = dlpf_eff;
	assign o_digital_lowpass_fir_off = (dlpf_eff == iccr_pkg::DLPF_BYPASS);

	// Bypass flags follow the codes that switch each filter out
	property p_dhpf_bypass;
		o_digital_highpass_bypass == (o_digital_highpass_select == 2'h0);
	endproperty
	a_dhpf_bypass: assert property (p_dhpf_bypass) else $error("dc coupling flag wrong");

	property p_fir_off;
		o_digital_lowpass_fir_off == (o_digital_lowpass_select == 2'h0);
	endproperty
	a_fir_off: assert property (p_fir_off) else $error("decimation-only flag wrong");

	// Checks on the rate decode, remap and read path

	property p_rate_fast;
		rate_reg == 1'b0 |-> o_rate_onehot[{i_master_clock_select, 1'b0}];
	endproperty
	a_rate_fast: assert property (p_rate_fast) else $error("fast rate not decoded");

	property p_rate_slow;
		rate_reg == 1'b1 |-> o_rate_onehot[{i_master_clock_select, 1'b1}];
	endproperty
	a_rate_slow: assert property (p_rate_slow) else $error("slow rate not decoded");

	property p_onehot;
		$onehot(o_rate_onehot);
	endproperty
	a_onehot: assert property (p_onehot) else $error("rate select not one-hot");

	property p_write_rate;
		s_write_hit ##1 1'b1 |-> o_impedance_rate_select == $past(i_wdata[iccr_pkg::RATE_BIT]);
	endproperty
	a_write_rate: assert property (p_write_rate) else $error("rate bit not written");

	property p_ahpf_bypass;
		o_analog_highpass_bypass == (ahpf_reg >= 3'h6);
	endproperty
	a_ahpf_bypass: assert property (p_ahpf_bypass) else $error("high-pass bypass wrong");

	property p_remap;
		(dlpf_reg == iccr_pkg::DLPF_16HZ && rate_reg)
			|-> o_digital_lowpass_select == iccr_pkg::DLPF_4HZ;
	endproperty
	a_remap: assert property (p_remap) else $error("unsupported low-pass not remapped");

	property p_keep_fast;
		!rate_reg |-> o_digital_lowpass_select == dlpf_reg;
	endproperty
	a_keep_fast: assert property (p_keep_fast) else $error("low-pass altered at fast rate");

	property p_read_back;
		s_read_hit |=> (o_rdata[iccr_pkg::DLPF_HI:iccr_pkg::DLPF_LO] == $past(dlpf_eff))
			&& (o_rdata[iccr_pkg::RATE_BIT] == $past(rate_reg));
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data wrong");

	property p_miss_keeps;
		(i_wr && !hit && i_clk_en) |=> $stable(view);
	endproperty
	a_miss_keeps: assert property (p_miss_keeps) else $error("unmapped write changed state");
endmodule

// >>> verification/tb_top.sv
/*
 Self-checking bench for the impedance channel configuration register.
 Assumes the design answers reads one cycle after the strobe, and that master clock
 select comes straight from the bench.
*/
`timescale 1ns/10ps
module tb_top;
	// Design connections
	logic i_core_clk, i_resetn, i_clk_en, i_wr, i_rd, ab, eb, ln, rs, db, fo;
	logic [7:0] i_addr, oh;
	logic [23:0] i_wdata, o_rdata, rv;
	logic [1:0] i_master_clock_select, gs, ds, ls;
	logic [2:0] as;
	int error_cnt, samples_checked;

	// Device under test
	iccr_impedance_channel_config_reg dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_master_clock_select(i_master_clock_select), .o_rate_onehot(oh),
		.o_impedance_rate_select(rs), .o_analog_highpass_select(as),
		.o_analog_highpass_bypass(ab), .o_external_bias_select(eb),
		.o_amp_low_noise_select(ln), .o_impedance_gain_select(gs),
		.o_digital_highpass_select(ds), .o_digital_highpass_bypass(db),
		.o_digital_lowpass_select(ls), .o_digital_lowpass_fir_off(fo));

	// Clock at 25 MHz
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	// Compare and count
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle write; returns 1 ns after the edge that stores the data
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; data sampled in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	// Reset values seen on the read path and the field outputs
	task automatic t_reset;
		rd(8'h18, rv);
		chk(rv, 24'h20_1000);
		chk({rs, as, eb, ln, gs, ds, ls, 12'h000}, 24'h20_1000);
		chk({21'h0, ab, db, fo}, 24'h00_0002);
	endtask

	// Every master clock and rate bit pair picks one rate line
	task automatic t_rates;
		for (int m = 0; m < 4; m++) begin
			for (int r = 0; r < 2; r++) begin
				@(posedge i_core_clk);
				i_master_clock_select <= m[1:0];
				wr(8'h18, {r[0], 23'h00_2000});
				chk({16'h0, oh}, {16'h0, 8'h01 << {m[1:0], r[0]}});
			end
		end
	endtask

	// Field words with bypass flags, low bits ignored, and the low-pass remap
	task automatic t_fields;
		logic [23:0] w [6] = '{24'h6F_AFFF, 24'h70_4000, 24'hD0_3000, 24'h50_3000,
			24'h80_3000, 24'h00_0000};
		logic [23:0] e [6] = '{24'h6F_A000, 24'h70_4000, 24'hD0_1000, 24'h50_3000,
			24'h80_1000, 24'h00_0000};
		logic [2:0] f [6] = '{3'b100, 3'b101, 3'b010, 3'b010, 3'b010, 3'b011};
		for (int k = 0; k < 6; k++) begin
			@(posedge i_core_clk);
			i_master_clock_select <= k[1:0];
			wr(8'h18, w[k]);
			chk({22'h0, ls}, {22'h0, e[k][13:12]});
			chk({rs, as, eb, ln, gs, ds, ls, 12'h000}, e[k]);
			chk({21'h0, ab, db, fo}, {21'h0, f[k]});
			rd(8'h18, rv);
			chk(rv, e[k]);
		end
	endtask

	// Unmapped address is ignored and reads zero; read data lasts one cycle
	task automatic t_unmapped;
		wr(8'h18, 24'h35_5000);
		wr(8'h19, 24'hFF_FFFF);
		rd(8'h19, rv);
		chk(rv, 24'h00_0000);
		rd(8'h18, rv);
		chk(rv, 24'h35_5000);
		@(posedge i_core_clk);
		#1 chk(o_rdata, 24'h00_0000);
	endtask

	// Clock enable low freezes the fields; a reset in mid-run restores the defaults
	task automatic t_freeze;
		@(posedge i_core_clk);
		i_clk_en <= 1'b0;
		wr(8'h18, 24'h00_0000);
		chk({rs, as, eb, ln, gs, ds, ls, 12'h000}, 24'h35_5000);
		@(posedge i_core_clk);
		i_clk_en <= 1'b1;
		i_resetn <= 1'b0;
		@(posedge i_core_clk);
		i_resetn <= 1'b1;
		rd(8'h18, rv);
		chk(rv, 24'h20_1000);
	endtask

	// Verdict and end of run
	task test_done;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		error_cnt = 0;
		samples_checked = 0;
		i_resetn = 1'b0;
		i_clk_en = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 24'h00_0000;
		i_master_clock_select = 2'h0;
		repeat (20) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_rates();
		t_fields();
		t_unmapped();
		t_freeze();
		test_done();
	end
endmodule
